// ---- dcc_analog_model.sv ----
/*
  dcc_analog_model: analog far side, levels in millivolts.
  assumes route selects negative channels and reference.
*/
`timescale 1ns/1ps
module dcc_analog_model
(
  input wire dcc_pkg::dcc_route_t route,
  input wire logic [3:0][7:0]     chanMv,
  input wire logic [7:0]          posOneMv,
  input wire logic [7:0]          posTwoMv,
  input wire logic [7:0]          refMv,
  output logic                    cmpOneRaw,
  output logic                    cmpTwoRaw
);
  import dcc_pkg::*;
  logic [7:0] plusOne;
  logic [7:0] plusTwo;
  assign plusOne = route.refToPositive ? refMv : posOneMv;
  assign plusTwo = route.refToPositive ? refMv : posTwoMv;
  assign cmpOneRaw = plusOne > chanMv[route.oneNegChannel];
  assign cmpTwoRaw = plusTwo > chanMv[route.twoNegChannel];
endmodule

// ---- dcc_comparator_ctrl.sv ----
/*
  dcc_comparator_ctrl: control register, change flag, interrupt and routing of two comparators.
  assumes an AHB-Lite master on clk, raw comparator decisions from the analog front end.
*/
//
// Notes on behaviour
// - a raw decision is high when the positive input is above the negative input, else low.
// - control bit 7 shows comparator two's decision, inverted when its invert bit is set.
// - control bit 6 shows comparator one's decision, inverted when its invert bit is set.
// - control bit 5 set inverts comparator two's output.
// - control bit 4 set inverts comparator one's output.
// - in configuration 110 the select bit routes negative inputs to channels 3/2 or 0/1.
// - control bits 2 to 0 select one of eight configurations.
// - reset clears result, invert and select bits and sets the configuration bits.
// - after a configuration change the outputs are marked not valid for a settling time.
// - outputs, normal or inverted, are readable and can be driven to pins.
// - the port-A direction bits keep controlling the comparator pins in every configuration.
// - configuration 111 turns both comparators off and is the reset value.
// - the change flag sets when either output changes; a software one also sets it.
// - a control register access ends the mismatch; until then the flag keeps setting.
// - the internal reference drives both positive inputs only in configuration 110.
`timescale 1ns/1ps
module dcc_comparator_ctrl
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 clkEn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 cmpOneRaw,
  input  wire logic                 cmpTwoRaw,
  input  wire logic [5:0]           portADirection,
  output dcc_pkg::dcc_route_t       route,
  output dcc_pkg::dcc_pinout_t      pinOut,
  output logic                      outputsValid,
  output logic                      irq
);
  import dcc_pkg::*;

  logic [7:0]          ctrl_r;
  logic [ST_W-1:0]     status_r;
  logic [ST_W-1:0]     mask_r;
  logic [1:0]          pinSel_r;
  logic [1:0]          latched_r;
  logic [SETTLE_W-1:0] settle_r;
  logic                wrPend_r;
  logic                rdPend_r;
  logic [DCC_ADDR_W-1:0] addr_r;
  logic [31:0]         hrdata_r;
  logic                irq_r;
  logic                valid_r;
  dcc_route_t          route_r;
  dcc_pinout_t         pin_r;

  logic       oneResult;
  logic       twoResult;
  logic [2:0] cfg;
  logic       addrPhase;
  logic       ctrlTouch;
  logic       mismatch;
  logic       cfgWrite;
  logic [ST_W-1:0] stSet;
  logic            forceEvt;
  dcc_route_t      routeNxt;
  dcc_pinout_t     pinNxt;

  assign cfg = ctrl_r[CTL_CFG_MSB:CTL_CFG_LSB];

  function automatic logic cmpOn(input logic [2:0] c, input logic two);
    unique case (c)
      CFG_RESET_ALL, CFG_OFF: cmpOn = 1'b0;
      CFG_ONE_IND:            cmpOn = ~two;
      default:                cmpOn = 1'b1;
    endcase
  endfunction

  // sync and polarity per comparator; raw polarity is the front end's
  dcc_sync_cmp uOne
  (
    .clk    (clk),
    .arst_n (arst_n),
    .clkEn  (clkEn),
    .rawIn  (cmpOneRaw),
    .enable (cmpOn(cfg, 1'b0)),
    .invert (ctrl_r[CTL_CMP_ONE_INVERT]),
    .result (oneResult)
  );

  dcc_sync_cmp uTwo
  (
    .clk    (clk),
    .arst_n (arst_n),
    .clkEn  (clkEn),
    .rawIn  (cmpTwoRaw),
    .enable (cmpOn(cfg, 1'b1)),
    .invert (ctrl_r[CTL_CMP_TWO_INVERT]),
    .result (twoResult)
  );

  // bus address phase
  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addr_r   <= '0;
    end
    else if (clkEn)
    begin
      wrPend_r <= addrPhase & hwrite;
      rdPend_r <= addrPhase & ~hwrite;
      if (addrPhase)
        addr_r <= haddr[DCC_ADDR_W-1:0];
    end
  end

  assign cfgWrite  = wrPend_r & (addr_r == DCC_OFS_CTRL);
  assign ctrlTouch = (wrPend_r | rdPend_r) & (addr_r == DCC_OFS_CTRL);

  // control register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_r <= CTL_RESET;
    else if (clkEn)
    begin
      if (cfgWrite)
      begin
        ctrl_r[CTL_CMP_TWO_INVERT] <= hwdata[CTL_CMP_TWO_INVERT];
        ctrl_r[CTL_CMP_ONE_INVERT] <= hwdata[CTL_CMP_ONE_INVERT];
        ctrl_r[CTL_NEG_SELECT]     <= hwdata[CTL_NEG_SELECT];
        ctrl_r[CTL_CFG_MSB:CTL_CFG_LSB] <= hwdata[CTL_CFG_MSB:CTL_CFG_LSB];
      end
      ctrl_r[CTL_CMP_TWO_RESULT] <= twoResult;
      ctrl_r[CTL_CMP_ONE_RESULT] <= oneResult;
    end
  end

  // last-accessed value (read or write) for mismatch detection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      latched_r <= 2'h0;
    else if (clkEn && ctrlTouch)
      latched_r <= {ctrl_r[CTL_CMP_TWO_RESULT], ctrl_r[CTL_CMP_ONE_RESULT]};
  end

  assign mismatch = ({ctrl_r[CTL_CMP_TWO_RESULT], ctrl_r[CTL_CMP_ONE_RESULT]} != latched_r)
                    & ~ctrlTouch;

  // settling counter after a configuration change
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      settle_r <= '0;
    else if (clkEn)
    begin
      if (cfgWrite && hwdata[CTL_CFG_MSB:CTL_CFG_LSB] != cfg)
        settle_r <= SETTLE_W'(SETTLE_CYC);
      else if (settle_r != '0)
        settle_r <= settle_r - SETTLE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      valid_r <= 1'b0;
    else if (clkEn)
      valid_r <= (settle_r == '0) & ~cfgWrite;
  end

  // sticky status; set wins over write-one-to-clear
  always_comb
  begin
    stSet            = '0;
    stSet[ST_CHANGE] = mismatch | forceEvt;
    stSet[ST_SETTLE] = (settle_r == SETTLE_W'(1));
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status_r <= '0;
    else if (clkEn)
    begin
      if (wrPend_r && addr_r == DCC_OFS_STATUS)
        status_r <= (status_r & ~hwdata[ST_W-1:0]) | stSet;
      else
        status_r <= status_r | stSet;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask_r   <= '0;
      pinSel_r <= 2'h0;
    end
    else if (clkEn && wrPend_r)
    begin
      if (addr_r == DCC_OFS_MASK)
        mask_r <= hwdata[ST_W-1:0];
      if (addr_r == DCC_OFS_PIN)
        pinSel_r <= hwdata[1:0];
    end
  end

  // software-forced change event sets the flag like a real one
  // (writing 1 to bit 0 of the settle/force register)
  always_comb
  begin
    forceEvt = wrPend_r & (addr_r == DCC_OFS_SETTLE) & hwdata[ST_CHANGE];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_r <= 1'b0;
    else if (clkEn)
      irq_r <= |(status_r & mask_r);
  end

  // routing decode
  always_comb
  begin
    routeNxt               = '0;
    routeNxt.cmpOneEn      = cmpOn(cfg, 1'b0);
    routeNxt.cmpTwoEn      = cmpOn(cfg, 1'b1);
    routeNxt.oneNegChannel = 2'h0;
    routeNxt.twoNegChannel = 2'h1;
    if (cfg == CFG_FOUR_MUX)
    begin
      routeNxt.refToPositive = 1'b1;
      if (ctrl_r[CTL_NEG_SELECT])
      begin
        routeNxt.oneNegChannel = 2'h3;
        routeNxt.twoNegChannel = 2'h2;
      end
    end
  end

  always_comb
  begin
    pinNxt           = '0;
    pinNxt.oneResult = oneResult;
    pinNxt.twoResult = twoResult;
    // pin drives only where the direction bit says output and, outside configurations 100 and 101, pinSel_r routes it out and it is on
    pinNxt.oneOutEn = pinSel_r[0] & routeNxt.cmpOneEn & ~portADirection[4];
    pinNxt.twoOutEn = pinSel_r[1] & routeNxt.cmpTwoEn & ~portADirection[5];
    if (cfg == CFG_TWO_OUT || cfg == CFG_TWO_COM_OUT)
    begin
      pinNxt.oneOutEn = ~portADirection[4];
      pinNxt.twoOutEn = ~portADirection[5];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      route_r <= '0;
      pin_r   <= '0;
    end
    else if (clkEn)
    begin
      route_r <= routeNxt;
      pin_r   <= pinNxt;
    end
  end

  // read data, registered in the address phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hrdata_r <= '0;
    else if (clkEn && addrPhase && !hwrite)
    begin
      unique case (haddr[DCC_ADDR_W-1:0])
        DCC_OFS_CTRL:   hrdata_r <= {24'h0, ctrl_r};
        DCC_OFS_STATUS: hrdata_r <= {30'h0, status_r};
        DCC_OFS_MASK:   hrdata_r <= {30'h0, mask_r};
        DCC_OFS_PIN:    hrdata_r <= {30'h0, pinSel_r};
        DCC_OFS_SETTLE: hrdata_r <= {31'h0, valid_r};
        default:        hrdata_r <= 32'h0;
      endcase
    end
  end

  assign hrdata       = hrdata_r;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign irq          = irq_r;
  assign route        = route_r;
  assign pinOut       = pin_r;
  assign outputsValid = valid_r;
endmodule

// ---- dcc_ctrl_props.sv ----
/*
  dcc_ctrl_props: port assertions for dcc_comparator_ctrl.
  assumes one clock domain and a zero-wait bus slave.
*/
`timescale 1ns/1ps
module dcc_ctrl_props
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  input wire logic [5:0]           portADirection,
  input wire dcc_pkg::dcc_route_t  route,
  input wire dcc_pkg::dcc_pinout_t pinOut,
  input wire logic                 outputsValid
);
  import dcc_pkg::*;
  logic       wrCtl_r;
  logic       rdCtl_r;
  logic [5:0] ctl_r;
  wire  logic take = hsel && hready && htrans == HTRANS_NONSEQ && haddr[7:0] == DCC_OFS_CTRL;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      wrCtl_r <= 1'b0;
      rdCtl_r <= 1'b0;
    end
    else
    begin
      wrCtl_r <= take && hwrite;
      rdCtl_r <= take && !hwrite;
    end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      ctl_r <= CTL_RESET[5:0];
    else if (wrCtl_r)
      ctl_r <= hwdata[5:0];
  default clocking dflt @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_ctl_readback: assert property (rdCtl_r |-> hrdata[5:0] == ctl_r)
    else $error("control readback wrong");
  chk_off_mode: assert property (wrCtl_r && hwdata[2:0] == 3'h7
    |-> ##[1:3] !route.cmpOneEn && !route.cmpTwoEn) else $error("comparators not off");
  chk_mux_high: assert property (wrCtl_r && hwdata[3:0] == 4'he |-> ##[1:3]
    route.refToPositive && route.oneNegChannel == 2'h3 && route.twoNegChannel == 2'h2)
    else $error("switched routing wrong");
  chk_mux_low: assert property (wrCtl_r && hwdata[3:0] == 4'h6 |-> ##[1:3]
    route.oneNegChannel == 2'h0 && route.twoNegChannel == 2'h1) else $error("routing wrong");
  chk_ref_only: assert property (route.refToPositive
    |-> ctl_r[2:0] == 3'h6 || $past(wrCtl_r)) else $error("reference outside mode");
  chk_pin_dir: assert property (pinOut.oneOutEn |-> !$past(portADirection[4]))
    else $error("pin driven while input");
  chk_settle_drop: assert property (wrCtl_r && hwdata[2:0] != ctl_r[2:0]
    |-> ##[1:3] !outputsValid) else $error("valid kept after mode change");
  chk_settle_hold: assert property ($fell(outputsValid) |-> !outputsValid [*8])
    else $error("valid back too soon");
endmodule

// ---- dcc_pkg.sv ----
/*
  dcc_pkg: constants, register map and carrier types of the dual comparator control block.
  assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
*/
package dcc_pkg;
  // register byte offsets
  localparam logic [7:0] DCC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DCC_OFS_STATUS = 8'h04;
  localparam logic [7:0] DCC_OFS_MASK   = 8'h08;
  localparam logic [7:0] DCC_OFS_PIN    = 8'h0c;
  localparam logic [7:0] DCC_OFS_SETTLE = 8'h10;
  localparam int unsigned DCC_ADDR_W = 8;

  // control register field positions
  localparam int unsigned CTL_CMP_TWO_RESULT = 7;
  localparam int unsigned CTL_CMP_ONE_RESULT = 6;
  localparam int unsigned CTL_CMP_TWO_INVERT = 5;
  localparam int unsigned CTL_CMP_ONE_INVERT = 4;
  localparam int unsigned CTL_NEG_SELECT     = 3;
  localparam int unsigned CTL_CFG_MSB        = 2;
  localparam int unsigned CTL_CFG_LSB        = 0;

  // status / mask bit positions
  localparam int unsigned ST_CHANGE = 0;
  localparam int unsigned ST_SETTLE = 1;
  localparam int unsigned ST_W      = 2;

  // reset values
  localparam logic [7:0] CTL_RESET  = 8'h07;
  localparam logic [2:0] CFG_RESET  = 3'h7;
  localparam logic [5:0] PIN_RESET  = 6'h3f;

  // settling time after a configuration change
  localparam int unsigned SETTLE_NS  = 10000;
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_W   = 11;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [2:0]
  {
    CFG_RESET_ALL   = 3'b000,
    CFG_ONE_IND     = 3'b001,
    CFG_TWO_IND     = 3'b010,
    CFG_TWO_COMMON  = 3'b011,
    CFG_TWO_OUT     = 3'b100,
    CFG_TWO_COM_OUT = 3'b101,
    CFG_FOUR_MUX    = 3'b110,
    CFG_OFF         = 3'b111
  } dcc_cfg_t;

  // analog routing selection handed to the comparator front end
  typedef struct packed
  {
    logic       cmpOneEn;
    logic       cmpTwoEn;
    logic       refToPositive;
    logic [1:0] oneNegChannel;
    logic [1:0] twoNegChannel;
  } dcc_route_t;

  // comparator outputs towards the pins
  typedef struct packed
  {
    logic twoResult;
    logic oneResult;
    logic twoOutEn;
    logic oneOutEn;
  } dcc_pinout_t;
endpackage

// ---- dcc_sync_cmp.sv ----
/*
  dcc_sync_cmp: two-stage synchroniser and polarity stage for one comparator.
  assumes the raw decision is asynchronous to clk.
*/
`timescale 1ns/1ps
module dcc_sync_cmp
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic clkEn,
  input  wire logic rawIn,
  input  wire logic enable,
  input  wire logic invert,
  output logic      result
);
  import dcc_pkg::*;

  logic meta_r;
  logic sync_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else if (clkEn)
    begin
      meta_r <= rawIn;
      sync_r <= meta_r;
    end
  end

  // an off comparator reads low before inversion
  assign result = (enable & sync_r) ^ invert;
endmodule

// ---- tb_top.sv ----
/*
  tb_top: self-checking bench for dcc_comparator_ctrl.
  assumes zero-wait AHB-Lite slave, 100 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import dcc_pkg::*;
  logic            clk, arst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic            cmpOneRaw, cmpTwoRaw, outputsValid;
  logic [1:0]      htrans;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic [5:0]      portADirection;
  logic [3:0][7:0] chanMv;
  logic [7:0]      posOneMv, posTwoMv, refMv;
  logic [3:0]      v;
  dcc_route_t      route;
  dcc_pinout_t     pinOut;
  int              failures, comparisons;
  dcc_comparator_ctrl dcc_comparator_ctrl_i
  (
    .clk, .arst_n, .clkEn(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmpOneRaw, .cmpTwoRaw,
    .portADirection, .route, .pinOut, .outputsValid, .irq
  );
  dcc_analog_model dcc_analog_model_i
  (
    .route, .chanMv, .posOneMv, .posTwoMv, .refMv, .cmpOneRaw, .cmpTwoRaw
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    failures++;
    end_sim;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {failures, comparisons} = '0;
    arst_n = 1'b0;
    chanMv = {4{8'h64}};
    posOneMv = 8'h32;
    posTwoMv = 8'h32;
    refMv = 8'hc8;
    portADirection = 6'h3f;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk(DCC_OFS_CTRL, 32'hff, 32'h07);
    check({31'h0, irq}, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, DCC_OFS_CTRL, 32'h8 | 32'(c));
      rdchk(DCC_OFS_CTRL, 32'h3f, 32'h8 | 32'(c));
      check({31'h0, route.refToPositive}, {31'h0, c == 6});
      check({31'h0, route.cmpOneEn | route.cmpTwoEn}, {31'h0, c != 0 && c != 7});
    end
    bus(1'b1, DCC_OFS_CTRL, 32'h02);
    repeat (3) @(posedge clk);
    rdchk(DCC_OFS_SETTLE, 32'h1, 32'h0);
    repeat (SETTLE_CYC) @(posedge clk);
    rdchk(DCC_OFS_SETTLE, 32'h1, 32'h1);
    for (int i = 0; i < 16; i++)
    begin
      v = 4'(i);
      posOneMv <= v[2] ? 8'hc8 : 8'h32;
      posTwoMv <= v[3] ? 8'hc8 : 8'h32;
      bus(1'b1, DCC_OFS_CTRL, {24'h0, 2'h3, v[1:0], 4'h2});
      repeat (6) @(posedge clk);
      rdchk(DCC_OFS_CTRL, 32'hff, {24'h0, v[3] ^ v[1], v[2] ^ v[0], v[1:0], 4'h2});
    end
    bus(1'b1, DCC_OFS_MASK, 32'h1);
    bus(1'b0, DCC_OFS_CTRL, 32'h0);
    bus(1'b1, DCC_OFS_STATUS, 32'h3);
    rdchk(DCC_OFS_STATUS, 32'h1, 32'h0);
    check({31'h0, irq}, 32'h0);
    posOneMv <= 8'h32;
    repeat (6) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, DCC_OFS_STATUS, 32'h1);
    rdchk(DCC_OFS_STATUS, 32'h1, 32'h1);
    bus(1'b0, DCC_OFS_CTRL, 32'h0);
    bus(1'b1, DCC_OFS_STATUS, 32'h1);
    rdchk(DCC_OFS_STATUS, 32'h1, 32'h0);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, DCC_OFS_MASK, 32'h0);
    posOneMv <= 8'hc8;
    repeat (6) @(posedge clk);
    rdchk(DCC_OFS_STATUS, 32'h1, 32'h1);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, DCC_OFS_PIN, 32'h3);
    bus(1'b1, DCC_OFS_CTRL, 32'h05);
    portADirection <= 6'h1f;
    repeat (6) @(posedge clk);
    check({28'h0, pinOut}, 32'he);
    portADirection <= 6'h2f;
    repeat (4) @(posedge clk);
    check({28'h0, pinOut}, 32'hd);
    bus(1'b1, DCC_OFS_CTRL, 32'h06);
    rdchk(8'h20, 32'hffffffff, 32'h0);
    bus(1'b0, DCC_OFS_CTRL, 32'h0);
    bus(1'b1, DCC_OFS_STATUS, 32'h3);
    rdchk(DCC_OFS_STATUS, 32'h1, 32'h0);
    bus(1'b1, DCC_OFS_SETTLE, 32'h1);
    rdchk(DCC_OFS_STATUS, 32'h1, 32'h1);
    repeat (2) @(posedge clk);
    end_sim;
  end
endmodule
bind dcc_comparator_ctrl dcc_ctrl_props dcc_ctrl_props_i
(
  .clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .portADirection, .route, .pinOut, .outputsValid
);
